// >>> inc/usb_attach_pkg.sv
// Package with register map, field layout, reset values and shared types for the USB attach block
package usb_attach_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PINSEL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0C;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_READY_BIT = 0;     // Software ready to enumerate
    localparam int CTRL_SELF_PWR_BIT = 1;  // Self powered operation
    localparam int CTRL_EXT_PU_BIT = 2;    // External pull-up on a general-purpose pin
    localparam int CTRL_AUDIO_BIT = 3;     // Audio endpoint layout
    localparam int CTRL_WIDTH = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;  // Internal pull-up, bus powered, transport layout

    // ------------------------------------------------------------
    // Pin selection fields and reset values
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 16;
    localparam int PIN_SEL_W = 4;
    localparam int PS_PULLUP_LSB = 0;
    localparam int PS_VBUS_LSB = 4;
    localparam int PS_UNPLUG_LSB = 8;
    localparam int PS_WAKE_LSB = 12;
    localparam logic [15:0] PINSEL_RESET = 16'h3210;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int ST_VBUS_BIT = 0;
    localparam int ST_DETACHED_BIT = 1;
    localparam int ST_PULLUP_BIT = 2;
    localparam int ST_SUSPEND_BIT = 3;
    localparam int ST_ADDR_LSB = 8;
    localparam int ST_FIFO_BIT = 15;
    localparam int ST_POWER_LSB = 16;

    // ------------------------------------------------------------
    // Bus power request: 100 mA in 2 mA descriptor units
    // ------------------------------------------------------------
    localparam int BUS_CURRENT_MA = 100;
    localparam int POWER_UNIT_MA = 2;
    localparam logic [7:0] MAX_POWER_UNITS = 8'(BUS_CURRENT_MA / POWER_UNIT_MA);

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [6:0] DEFAULT_ADDR = 7'h00;

    // Attachment states
    typedef enum logic [1:0] {ST_UNPLUGGED, ST_WAIT_VBUS, ST_ATTACHED, ST_SUSPENDED} attach_state_t;

    // Transmit line drive from the serial engine
    typedef struct packed {
        logic en;
        logic dp;
        logic dn;
    } line_drive_t;

    // Received byte from the serial engine
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rx_word_t;

endpackage

// >>> rtl/usb_rx_fifo.sv
// Synchronous FIFO with valid and ready on both sides and a registered ready
`timescale 1ns/10ps
`default_nettype none
module usb_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW-1:0] wr_ptr;          // Write pointer
    logic [AW-1:0] rd_ptr;          // Read pointer
    logic [AW:0] count;             // Fill level
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Pointers and level; ready is registered from the next level so it never lags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else if (ce) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
                in_ready <= 1'b1;
            end else begin
                if (push) wr_ptr <= wr_ptr + 1'b1;
                if (pop) rd_ptr <= rd_ptr + 1'b1;
                count <= next_count;
                in_ready <= (next_count < (AW+1)'(DEPTH));
            end
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge clk) begin
        if (ce && push && !flush) mem[wr_ptr] <= in_data;
    end
endmodule
`default_nettype wire

// >>> rtl/usb_attach_control.sv
// USB attachment control: pull-up, VBUS sense, suspend, detach and wake, APB registers
//
// Contract
// - Full-speed function only, never a host
// - Only answer host requests; host starts all
// - Selectable transport or audio endpoint layout
// - Pull D+ up only when ready
// - Internal or pin pull-up, internal by default
// - Self powered: no pull-up without VBUS
// - VBUS sense pin chosen by number
// - Bus powered: declare 100 mA
// - Enter suspend when host commands it
// - Radio off when bus powered and suspended
// - Pins switch off lights and amplifiers
// - Detach and wake pins chosen by number
// - Detach high: lines floating, pull-up off
// - Detach low: restore pull-up, await enumeration
// - Wake output high only while detached
// - No in-band resume while detached
`timescale 1ns/10ps
`default_nettype none
module usb_attach_control (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // General-purpose pins
    input wire logic [15:0] general_purpose_pin_in,
    output logic [15:0] general_purpose_pin_out,
    output logic [15:0] general_purpose_pin_oe,
    // USB data lines and internal pull-up
    output logic usb_d_plus_pin_out,
    output logic usb_d_minus_pin_out,
    output logic usb_d_plus_pin_oe,
    output logic usb_d_minus_pin_oe,
    output logic internal_pullup_en,
    // Serial engine side
    input wire usb_attach_pkg::line_drive_t tx_drive,
    input wire usb_attach_pkg::rx_word_t rx_word,
    output logic rx_ready,
    input wire logic suspend_req,
    input wire logic set_addr_stb,
    input wire logic [6:0] set_addr_val,
    input wire logic resume_req,
    output logic resume_en,
    output logic [6:0] usb_addr,
    output logic audio_layout,
    output logic [7:0] max_power,
    // Power control
    output logic radio_en,
    output logic peripherals_off
);
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [3:0] ctrl;                      // Software control bits
    logic [15:0] pinsel;                   // Pin numbers for each function
    logic [15:0] gp_meta;                  // First synchroniser stage
    logic [15:0] gp_sync;                  // Second synchroniser stage
    usb_attach_pkg::attach_state_t state;  // Attachment state
    usb_attach_pkg::attach_state_t next_state;
    logic detached;                        // Registered unplug level
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic pick_pin(input logic [15:0] pins, input logic [3:0] sel);
        pick_pin = pins[sel];
    endfunction

    wire [3:0] sel_pullup = pinsel[usb_attach_pkg::PS_PULLUP_LSB +: usb_attach_pkg::PIN_SEL_W];
    wire [3:0] sel_vbus = pinsel[usb_attach_pkg::PS_VBUS_LSB +: usb_attach_pkg::PIN_SEL_W];
    wire [3:0] sel_unplug = pinsel[usb_attach_pkg::PS_UNPLUG_LSB +: usb_attach_pkg::PIN_SEL_W];
    wire [3:0] sel_wake = pinsel[usb_attach_pkg::PS_WAKE_LSB +: usb_attach_pkg::PIN_SEL_W];
    wire ready = ctrl[usb_attach_pkg::CTRL_READY_BIT];
    wire self_pwr = ctrl[usb_attach_pkg::CTRL_SELF_PWR_BIT];
    wire ext_pu = ctrl[usb_attach_pkg::CTRL_EXT_PU_BIT];
    // VBUS sense read from the chosen pin
    wire vbus_seen = pick_pin(gp_sync, sel_vbus);
    // Unplug request read from the chosen pin
    wire unplug_req = pick_pin(gp_sync, sel_unplug);
    // Without self power the cable powers us, so VBUS is present by definition
    wire vbus_ok = !self_pwr || vbus_seen;
    wire pullup_on = (state == usb_attach_pkg::ST_ATTACHED) || (state == usb_attach_pkg::ST_SUSPENDED);
    wire next_pullup = (next_state == usb_attach_pkg::ST_ATTACHED)
        || (next_state == usb_attach_pkg::ST_SUSPENDED);
    wire next_suspended = (next_state == usb_attach_pkg::ST_SUSPENDED);

    // APB decode
    wire apb_access = psel && penable && !pready;
    wire hit_ctrl = (paddr == usb_attach_pkg::CTRL_OFS);
    wire hit_pinsel = (paddr == usb_attach_pkg::PINSEL_OFS);
    wire hit_status = (paddr == usb_attach_pkg::STATUS_OFS);
    wire hit_data = (paddr == usb_attach_pkg::DATA_OFS);
    wire hit_any = hit_ctrl || hit_pinsel || hit_status || hit_data;
    wire write_ok = hit_ctrl || hit_pinsel;
    wire bad_access = pwrite ? !write_ok : !hit_any;
    wire data_pop = apb_access && !pwrite && hit_data;

    // Status word
    wire [31:0] status_word = {8'h00, max_power, fifo_out_valid, usb_addr, 4'h0,
        (state == usb_attach_pkg::ST_SUSPENDED), pullup_on, detached, vbus_seen};
    wire [31:0] read_mux =
        hit_ctrl ? {28'h0000000, ctrl} :
        hit_pinsel ? {16'h0000, pinsel} :
        hit_status ? status_word :
        hit_data ? {23'h000000, fifo_out_valid, fifo_out_data} : 32'h00000000;

    // Detached: bytes from the line are accepted and dropped so nothing stalls
    wire fifo_in_valid = rx_word.valid && !detached;
    wire fifo_in_ready;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Two stages; only the second stage feeds the decoders
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gp_meta <= 16'h0000;
            gp_sync <= 16'h0000;
        end else if (ce) begin
            gp_meta <= general_purpose_pin_in;
            gp_sync <= gp_meta;
        end
    end

    // ------------------------------------------------------------
    // Attachment state machine
    // ------------------------------------------------------------
    // Unplug wins over everything, then missing VBUS, then suspend
    always_comb begin
        next_state = state;
        case (state)
            usb_attach_pkg::ST_UNPLUGGED: begin
                if (!unplug_req) next_state = usb_attach_pkg::ST_WAIT_VBUS;
            end
            usb_attach_pkg::ST_WAIT_VBUS: begin
                if (unplug_req) next_state = usb_attach_pkg::ST_UNPLUGGED;
                else if (ready && vbus_ok) next_state = usb_attach_pkg::ST_ATTACHED;
            end
            usb_attach_pkg::ST_ATTACHED: begin
                if (unplug_req) next_state = usb_attach_pkg::ST_UNPLUGGED;
                else if (!ready || !vbus_ok) next_state = usb_attach_pkg::ST_WAIT_VBUS;
                else if (suspend_req) next_state = usb_attach_pkg::ST_SUSPENDED;
            end
            usb_attach_pkg::ST_SUSPENDED: begin
                if (unplug_req) next_state = usb_attach_pkg::ST_UNPLUGGED;
                else if (!ready || !vbus_ok) next_state = usb_attach_pkg::ST_WAIT_VBUS;
                else if (!suspend_req) next_state = usb_attach_pkg::ST_ATTACHED;
            end
            default: begin
                next_state = usb_attach_pkg::ST_UNPLUGGED;
            end
        endcase
    end

    // State register; start unplugged so the pull-up is off from reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= usb_attach_pkg::ST_UNPLUGGED;
            detached <= 1'b1;
        end else if (ce) begin
            state <= next_state;
            detached <= (next_state == usb_attach_pkg::ST_UNPLUGGED);
        end
    end

    // ------------------------------------------------------------
    // Line and pull-up drive
    // ------------------------------------------------------------
    // Lines only driven when the engine answers the host and we are attached or suspended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_d_plus_pin_out <= 1'b0;
            usb_d_minus_pin_out <= 1'b0;
            usb_d_plus_pin_oe <= 1'b0;
            usb_d_minus_pin_oe <= 1'b0;
            internal_pullup_en <= 1'b0;
        end else if (ce) begin
            usb_d_plus_pin_out <= tx_drive.dp;
            usb_d_minus_pin_out <= tx_drive.dn;
            usb_d_plus_pin_oe <= tx_drive.en && next_pullup;
            usb_d_minus_pin_oe <= tx_drive.en && next_pullup;
            internal_pullup_en <= next_pullup && !ext_pu;
        end
    end

    // General-purpose pin outputs: external pull-up and wake
    // The wake pin is only enabled while detached, so it never fights the host otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_purpose_pin_out <= 16'h0000;
            general_purpose_pin_oe <= 16'h0000;
        end else if (ce) begin
            for (int i = 0; i < usb_attach_pkg::PIN_COUNT; i++) begin
                if (ext_pu && (sel_pullup == 4'(i))) begin
                    general_purpose_pin_out[i] <= next_pullup;
                    general_purpose_pin_oe[i] <= next_pullup;
                end else if (sel_wake == 4'(i)) begin
                    general_purpose_pin_out[i] <= resume_req && (next_state == usb_attach_pkg::ST_UNPLUGGED);
                    general_purpose_pin_oe[i] <= (next_state == usb_attach_pkg::ST_UNPLUGGED);
                end else begin
                    general_purpose_pin_out[i] <= 1'b0;
                    general_purpose_pin_oe[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Engine side controls
    // ------------------------------------------------------------
    // Address set by the host; reverts to default while unplugged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_addr <= usb_attach_pkg::DEFAULT_ADDR;
            resume_en <= 1'b0;
            audio_layout <= 1'b0;
            max_power <= 8'h00;
            radio_en <= 1'b0;
            peripherals_off <= 1'b1;
        end else if (ce) begin
            if (next_state == usb_attach_pkg::ST_UNPLUGGED) usb_addr <= usb_attach_pkg::DEFAULT_ADDR;
            else if (set_addr_stb) usb_addr <= set_addr_val;
            resume_en <= next_suspended;
            audio_layout <= ctrl[usb_attach_pkg::CTRL_AUDIO_BIT];
            // Self powered functions report zero bus current
            max_power <= self_pwr ? 8'h00 : usb_attach_pkg::MAX_POWER_UNITS;
            radio_en <= !(next_suspended && !self_pwr);
            peripherals_off <= next_suspended;
        end
    end

    // ------------------------------------------------------------
    // APB slave: one wait state, error on unmapped or read-only writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= usb_attach_pkg::CTRL_RESET;
            pinsel <= usb_attach_pkg::PINSEL_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= apb_access;
            pslverr <= apb_access && bad_access;
            if (apb_access && pwrite && hit_ctrl) ctrl <= pwdata[3:0];
            if (apb_access && pwrite && hit_pinsel) pinsel <= pwdata[15:0];
            prdata <= (apb_access && !pwrite) ? read_mux : 32'h00000000;
        end
    end

    // Received data buffer; it holds bytes until software drains them or a detach flushes them
    usb_rx_fifo #(.WIDTH(usb_attach_pkg::DATA_W), .DEPTH(usb_attach_pkg::FIFO_DEPTH)) rx_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .flush(detached),
        .in_valid(fifo_in_valid),
        .in_data(rx_word.data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(data_pop)
    );

    // No back-pressure reaches the engine; rx_ready stays high, so bytes are swallowed while detached or the FIFO is full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rx_ready <= 1'b0;
        else if (ce) rx_ready <= 1'b1;
    end
    wire unused_ready = fifo_in_ready;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // One clock domain: one default clock and reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Unplug pin seen on an enabled edge
    sequence s_unplug_seen;
        ce && unplug_req;
    endsequence

    // Unplug pin released while still detached
    sequence s_unplug_gone;
        ce && detached && !unplug_req;
    endsequence

    // All that attaching needs, internal source chosen
    sequence s_attach_allowed;
        ce && !unplug_req && ready && vbus_ok && !ext_pu;
    endsequence

    // Registered pull-up may lag ready by one cycle
    property p_pullup_needs_ready;
        (internal_pullup_en || (usb_d_plus_pin_oe)) |-> ready || $past(ready);
    endproperty
    a_pullup_needs_ready: assert property (p_pullup_needs_ready) else $error("pull-up without ready");

    // Never both pull-up sources at once
    property p_ext_pullup;
        ce && ext_pu |=> !internal_pullup_en;
    endproperty
    a_ext_pullup: assert property (p_ext_pullup) else $error("internal pull-up with external mode");

    // VBUS loss drops the pull-up one cycle after the synchronised pin
    property p_no_vbus;
        ce && self_pwr && !vbus_seen |=> !internal_pullup_en;
    endproperty
    a_no_vbus: assert property (p_no_vbus) else $error("pull-up while VBUS absent");

    // Bus powered current request
    property p_power;
        ce && !self_pwr |=> max_power == usb_attach_pkg::MAX_POWER_UNITS;
    endproperty
    a_power: assert property (p_power) else $error("bus current request not 100 mA");

    // Suspend takes lights and amplifiers along
    property p_suspend;
        ce && state == usb_attach_pkg::ST_ATTACHED && !unplug_req && ready && vbus_ok && suspend_req
            |=> state == usb_attach_pkg::ST_SUSPENDED && peripherals_off;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend not entered");

    // Radio off keeps the suspend budget
    property p_radio;
        ce && next_suspended && !self_pwr |=> !radio_en;
    endproperty
    a_radio: assert property (p_radio) else $error("radio on in bus powered suspend");

    // Unplug acts one cycle after the synchronised pin
    property p_detach;
        s_unplug_seen |=> !internal_pullup_en && !usb_d_plus_pin_oe && !usb_d_minus_pin_oe
            && usb_addr == 7'h00 && !resume_en;
    endproperty
    a_detach: assert property (p_detach) else $error("detach not honoured");

    // One edge to leave unplugged, one more to attach
    property p_reattach;
        s_unplug_gone ##1 s_attach_allowed |=> internal_pullup_en;
    endproperty
    a_reattach: assert property (p_reattach) else $error("no reattach after detach");

    // Wake pin belongs to the detached state only
    property p_wake_only_detached;
        (general_purpose_pin_oe[sel_wake] && !(ext_pu && sel_pullup == sel_wake)) |-> detached;
    endproperty
    a_wake_only_detached: assert property (p_wake_only_detached) else $error("wake driven while attached");

    // A taken access is answered next cycle, and only once
    property p_one_wait;
        ce && apb_access |=> pready && !apb_access;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not answered in time");

    // Detached: no in-band resume, the wake pin does it
    property p_resume_off;
        ce && detached |=> !resume_en;
    endproperty
    a_resume_off: assert property (p_resume_off) else $error("in-band resume while detached");
endmodule
`default_nettype wire

// >>> verification/usb_host_model.sv
// Host-side model that drives the serial engine inputs of the attach block
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Cable state and bench commands
    input wire logic pulled_up,
    input wire logic cmd_addr,
    input wire logic cmd_rx,
    input wire logic cmd_susp,
    // Serial engine side
    output var usb_attach_pkg::line_drive_t tx_drive,
    output var usb_attach_pkg::rx_word_t rx_word,
    output logic set_addr_stb,
    output logic [6:0] set_addr_val,
    output logic suspend_req
);
    logic [7:0] cnt; // Value of the next byte sent
    // ----------------------------------------
    // Host traffic
    // ----------------------------------------
    // The host only talks to a function that shows its pull-up, so no traffic reaches a detached block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_addr_stb <= 1'b0;
            rx_word <= '0;
            cnt <= 8'h00;
            suspend_req <= 1'b0;
        end else begin
            set_addr_stb <= cmd_addr & pulled_up;
            rx_word.valid <= cmd_rx & pulled_up;
            rx_word.data <= cnt;
            cnt <= cnt + 8'((cmd_rx & pulled_up) ? 1 : 0);
            suspend_req <= cmd_susp & pulled_up;
        end
    end
    assign set_addr_val = 7'h2A; // Address handed out at enumeration
    assign tx_drive = '{en: 1'b1, dp: 1'b1, dn: 1'b0}; // Idle J state
endmodule
`default_nettype wire

// >>> verification/usb_attach_control_tb.sv
// Self-checking bench for the USB attach block
`timescale 1ns/10ps
`default_nettype none
module usb_attach_control_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, resume_req = 0;
    logic cmd_addr = 0, cmd_rx = 0, cmd_susp = 0, ce = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, dpo, dno, dpe, dne, pu, rxr, ren, aud, rad, poff, sas;
    logic [15:0] gin = 16'h0000, gout, goe;
    logic [6:0] sav, addr;
    logic [7:0] mp;
    usb_attach_pkg::line_drive_t txd;
    usb_attach_pkg::rx_word_t rxw;
    logic sreq;
    int err_total = 0, total_checks = 0;
    always #25 pclk = ~pclk; // 20 MHz
    usb_attach_control dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .general_purpose_pin_in(gin), .general_purpose_pin_out(gout), .general_purpose_pin_oe(goe),
        .usb_d_plus_pin_out(dpo), .usb_d_minus_pin_out(dno), .usb_d_plus_pin_oe(dpe),
        .usb_d_minus_pin_oe(dne), .internal_pullup_en(pu), .tx_drive(txd), .rx_word(rxw), .rx_ready(rxr),
        .suspend_req(sreq), .set_addr_stb(sas), .set_addr_val(sav), .resume_req(resume_req),
        .resume_en(ren), .usb_addr(addr), .audio_layout(aud), .max_power(mp), .radio_en(rad),
        .peripherals_off(poff));
    usb_host_model host_u (.pclk(pclk), .presetn(presetn), .pulled_up(pu | (goe[0] & gout[0])),
        .cmd_addr(cmd_addr), .cmd_rx(cmd_rx), .cmd_susp(cmd_susp), .tx_drive(txd), .rx_word(rxw),
        .set_addr_stb(sas), .set_addr_val(sav), .suspend_req(sreq));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) begin
            err_total++;
            test_done();
        end
    endtask
    // Pin changes pass a 2-flop synchroniser and the state step
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(0, usb_attach_pkg::CTRL_OFS, 0); chk(q, 32'h0);
        apb(0, usb_attach_pkg::PINSEL_OFS, 0); chk(q, 32'h3210);
        apb(0, usb_attach_pkg::STATUS_OFS, 0); chk(q[23:16], 8'h32);
        apb(0, 8'h10, 0); chk(e, 1'b1);
        apb(1, usb_attach_pkg::STATUS_OFS, 32'hF); chk(e, 1'b1);
        chk(pu, 1'b0);
    endtask
    task automatic t_attach;
        apb(1, usb_attach_pkg::CTRL_OFS, 32'h1);
        settle();
        chk({pu, dpe, dne, rad, poff}, 5'b11110);
        chk({dpo, dno, rxr}, 3'b101);
        apb(0, usb_attach_pkg::STATUS_OFS, 0); chk(q[2], 1'b1);
    endtask
    task automatic t_detach;
        @(posedge pclk) cmd_addr <= 1'b1;
        @(posedge pclk) cmd_addr <= 1'b0;
        settle(); chk(addr, 7'h2A);
        @(posedge pclk) begin gin[2] <= 1'b1; resume_req <= 1'b1; end
        settle();
        chk({pu, dpe, dne, addr, ren}, 11'h0);
        chk({goe[3], gout[3]}, 2'b11);
        @(posedge pclk) resume_req <= 1'b0;
        settle(); chk({goe[3], gout[3]}, 2'b10);
        @(posedge pclk) gin[2] <= 1'b0;
        settle(); chk({pu, goe[3], addr}, 9'h100);
    endtask
    // Overfill the FIFO, then drain it; the 17th read finds it empty
    task automatic t_fifo;
        @(posedge pclk) cmd_rx <= 1'b1;
        repeat (20) @(posedge pclk);
        cmd_rx <= 1'b0;
        for (int i = 0; i < 17; i++) begin
            apb(0, usb_attach_pkg::DATA_OFS, 0);
            chk(q[8:0], (i < 16) ? {1'b1, 8'(i)} : 9'h0);
        end
    endtask
    task automatic t_suspend;
        @(posedge pclk) cmd_susp <= 1'b1;
        settle(); chk({rad, poff, ren}, 3'b011);
        apb(0, usb_attach_pkg::STATUS_OFS, 0); chk(q[3], 1'b1);
        @(posedge pclk) cmd_susp <= 1'b0;
        settle();
    endtask
    task automatic t_selfpow;
        apb(1, usb_attach_pkg::CTRL_OFS, 32'h3);
        settle(); chk({pu, mp}, 9'h0);
        apb(1, usb_attach_pkg::PINSEL_OFS, 32'h3290);
        @(posedge pclk) gin[9] <= 1'b1;
        settle(); chk(pu, 1'b1);
        apb(1, usb_attach_pkg::CTRL_OFS, 32'h7);
        settle(); chk({pu, goe[0], gout[0]}, 3'b011);
        apb(1, usb_attach_pkg::CTRL_OFS, 32'h8);
        settle(); chk({aud, pu, goe[0]}, 3'b100);
        apb(1, usb_attach_pkg::PINSEL_OFS, 32'h6A90);
        @(posedge pclk) gin[10] <= 1'b1;
        settle(); chk({goe[6], goe[3]}, 2'b10);
    endtask
    // Enable low freezes the block, even against the unplug pin
    task automatic t_freeze;
        @(posedge pclk) begin ce <= 1'b0; gin[2] <= 1'b1; end
        settle(); chk({pu, goe[3]}, 2'b10);
        @(posedge pclk) ce <= 1'b1;
        settle(); chk({pu, goe[3]}, 2'b01);
        @(posedge pclk) gin[2] <= 1'b0;
        settle(); chk(pu, 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_attach();
        t_detach();
        t_fifo();
        t_suspend();
        t_freeze();
        t_selfpow();
        test_done();
    end
endmodule
`default_nettype wire
